// ==== core/sxal_params.svh ====
// Behaviour
// - When running alone without speed expansion, the device leaves both address buses and the sync output undriven.
// - A store-address word holds the 9-bit address in bits 0 to 8 and the valid flag in bit 9.
// - The master sets bit 10 of the store-address word so that all eleven bits have odd parity.
// - The master sends the store addresses of all sixteen input ports, one port per clock, in step with the sync pulse.
// - Port 0 is on the bus while sync is high, and port N follows exactly N clocks later.
// - A slave that receives address zero with the valid flag set discards that port's incoming packet.
// - A slave that receives a clear valid flag treats that port's packet as idle, whatever the address bits hold.
// - Slave input ports store their next packet at the address received for their port.
// - The master sends the read addresses of all sixteen output ports on the read-address bus, port 0 with sync and port N N clocks later.
// - A read-address word holds the address in bits 0 to 8, the valid flag in bit 9 and odd parity over bits 0 to 9 in bit 10.
// - Slave output ports read their next packet from the address received for their port.
// - In master role the sync output is a one-clock pulse framing each round; in slave role it has no function.
`ifndef SXAL_PARAMS_SVH
`define SXAL_PARAMS_SVH
`define SXAL_NUM_PORTS   16
`define SXAL_ADDR_W      9
`define SXAL_WORD_W      11
`define SXAL_VALID_BIT   9
`define SXAL_PARITY_BIT  10
`define SXAL_PORT_W      4
`endif

// ==== core/sxal_pkg.sv ====
package sxal_pkg;
    typedef enum logic [1:0] {
        SXAL_ROLE_ALONE  = 2'b00,
        SXAL_ROLE_MASTER = 2'b01,
        SXAL_ROLE_SLAVE  = 2'b10
    } sxal_role_t;

    typedef enum logic [1:0] {
        SXAL_ACT_IDLE    = 2'b00,
        SXAL_ACT_STORE   = 2'b01,
        SXAL_ACT_DISCARD = 2'b10
    } sxal_action_t;

    typedef enum logic [1:0] {
        SXAL_RX_HUNT = 2'b00,
        SXAL_RX_LOCK = 2'b01
    } sxal_rx_state_t;
endpackage

// ==== core/sxal_word_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sxal_params.svh"
module sxal_word_decode
    import sxal_pkg::*;
(
    input  wire logic [`SXAL_WORD_W-1:0] word,
    output logic      [`SXAL_ADDR_W-1:0] addr,
    output logic                         valid,
    output logic                         parity_ok,
    output sxal_action_t                 action
);
    always_comb begin
        addr      = word[`SXAL_ADDR_W-1:0];
        valid     = word[`SXAL_VALID_BIT];
        parity_ok = ^word;
        if (!valid) begin
            action = SXAL_ACT_IDLE;
        end else if (addr == '0) begin
            action = SXAL_ACT_DISCARD;
        end else begin
            action = SXAL_ACT_STORE;
        end
    end
endmodule // sxal_word_decode
`default_nettype wire

// ==== core/sxal_link.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sxal_params.svh"
module sxal_link
    import sxal_pkg::*;
#(
    parameter int NUM_PORTS = `SXAL_NUM_PORTS
) (
    input  wire logic                              core_clk,
    input  wire logic                              nrst,
    input  wire sxal_role_t                        role,
    // master side: current addresses of local controllers, flattened by port
    input  wire logic [NUM_PORTS*`SXAL_ADDR_W-1:0] store_addr_local,
    input  wire logic [NUM_PORTS-1:0]              store_valid_local,
    input  wire logic [NUM_PORTS*`SXAL_ADDR_W-1:0] read_addr_local,
    input  wire logic [NUM_PORTS-1:0]              read_valid_local,
    // link pins
    output logic                                   frame_sync_out,
    output logic                                   frame_sync_out_oe,
    input  wire logic                              frame_sync_in,
    input  wire logic [`SXAL_WORD_W-1:0]           store_addr_bus_in,
    output logic      [`SXAL_WORD_W-1:0]           store_addr_bus_out,
    output logic                                   store_addr_bus_oe,
    input  wire logic [`SXAL_WORD_W-1:0]           read_addr_bus_in,
    output logic      [`SXAL_WORD_W-1:0]           read_addr_bus_out,
    output logic                                   read_addr_bus_oe,
    // slave side: per-port commands for the local controllers
    output logic                                   in_cmd_strobe,
    output logic      [`SXAL_PORT_W-1:0]           in_cmd_port,
    output sxal_action_t                           in_cmd_action,
    output logic      [`SXAL_ADDR_W-1:0]           in_cmd_addr,
    output logic                                   out_cmd_strobe,
    output logic      [`SXAL_PORT_W-1:0]           out_cmd_port,
    output sxal_action_t                           out_cmd_action,
    output logic      [`SXAL_ADDR_W-1:0]           out_cmd_addr,
    output logic                                   parity_err
);
    initial begin
        if (NUM_PORTS != (1 << `SXAL_PORT_W)) begin
            $error("sxal_link: NUM_PORTS must equal 2**SXAL_PORT_W");
        end
    end

    logic is_master;
    logic is_slave;
    assign is_master = (role == SXAL_ROLE_MASTER);
    assign is_slave  = (role == SXAL_ROLE_SLAVE);

    // ---------------- master transmit ----------------
    logic [`SXAL_PORT_W-1:0] tx_slot;
    logic [`SXAL_PORT_W-1:0] next_tx_slot;
    logic [`SXAL_WORD_W-1:0] next_store_word;
    logic [`SXAL_WORD_W-1:0] next_read_word;
    logic [`SXAL_ADDR_W-1:0] sel_store_addr;
    logic [`SXAL_ADDR_W-1:0] sel_read_addr;
    logic                    sel_store_valid;
    logic                    sel_read_valid;

    assign next_tx_slot = is_master ? tx_slot + 1'b1 : '0;

    always_comb begin
        sel_store_addr  = store_addr_local[tx_slot*`SXAL_ADDR_W +: `SXAL_ADDR_W];
        sel_store_valid = store_valid_local[tx_slot];
        sel_read_addr   = read_addr_local[tx_slot*`SXAL_ADDR_W +: `SXAL_ADDR_W];
        sel_read_valid  = read_valid_local[tx_slot];
        next_store_word = {~^{sel_store_valid, sel_store_addr}, sel_store_valid, sel_store_addr};
        next_read_word  = {~^{sel_read_valid, sel_read_addr}, sel_read_valid, sel_read_addr};
    end

    // slot counter runs ahead by one so bus word and sync leave the same flops
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_slot <= '0;
        end else begin
            tx_slot <= next_tx_slot;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            store_addr_bus_out <= '0;
            read_addr_bus_out  <= '0;
            frame_sync_out     <= 1'b0;
        end else begin
            store_addr_bus_out <= is_master ? next_store_word : '0;
            read_addr_bus_out  <= is_master ? next_read_word : '0;
            frame_sync_out     <= is_master && (tx_slot == '0);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            store_addr_bus_oe <= 1'b0;
            read_addr_bus_oe  <= 1'b0;
            frame_sync_out_oe <= 1'b0;
        end else begin
            store_addr_bus_oe <= is_master;
            read_addr_bus_oe  <= is_master;
            // slave still drives a quiet low so the partner input never floats
            frame_sync_out_oe <= (role != SXAL_ROLE_ALONE);
        end
    end

    // ---------------- slave receive ----------------
    sxal_rx_state_t          rx_state;
    logic [`SXAL_PORT_W-1:0] rx_slot;
    logic [`SXAL_PORT_W-1:0] cur_port;
    logic                    rx_active;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rx_state <= SXAL_RX_HUNT;
        end else begin
            case (rx_state)
                SXAL_RX_HUNT: rx_state <= (is_slave && frame_sync_in) ? SXAL_RX_LOCK : SXAL_RX_HUNT;
                SXAL_RX_LOCK: rx_state <= is_slave ? SXAL_RX_LOCK : SXAL_RX_HUNT;
                default:      rx_state <= SXAL_RX_HUNT;
            endcase
        end
    end

    assign cur_port  = frame_sync_in ? '0 : rx_slot;
    assign rx_active = is_slave && (frame_sync_in || rx_state == SXAL_RX_LOCK);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rx_slot <= '0;
        end else begin
            rx_slot <= cur_port + 1'b1;
        end
    end

    logic [`SXAL_ADDR_W-1:0] st_addr;
    logic [`SXAL_ADDR_W-1:0] rd_addr;
    logic                    st_par_ok;
    logic                    rd_par_ok;
    sxal_action_t            st_act;
    sxal_action_t            rd_act;

    sxal_word_decode u_store_dec (
        .word      (store_addr_bus_in),
        .addr      (st_addr),
        .valid     (),
        .parity_ok (st_par_ok),
        .action    (st_act)
    );

    sxal_word_decode u_read_dec (
        .word      (read_addr_bus_in),
        .addr      (rd_addr),
        .valid     (),
        .parity_ok (rd_par_ok),
        .action    (rd_act)
    );

    // a word with bad parity is turned into idle rather than risk a wrong buffer write
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            in_cmd_strobe  <= 1'b0;
            in_cmd_port    <= '0;
            in_cmd_action  <= SXAL_ACT_IDLE;
            in_cmd_addr    <= '0;
        end else begin
            in_cmd_strobe  <= rx_active;
            in_cmd_port    <= cur_port;
            in_cmd_action  <= st_par_ok ? st_act : SXAL_ACT_IDLE;
            in_cmd_addr    <= st_addr;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            out_cmd_strobe <= 1'b0;
            out_cmd_port   <= '0;
            out_cmd_action <= SXAL_ACT_IDLE;
            out_cmd_addr   <= '0;
        end else begin
            out_cmd_strobe <= rx_active;
            out_cmd_port   <= cur_port;
            out_cmd_action <= rd_par_ok ? rd_act : SXAL_ACT_IDLE;
            out_cmd_addr   <= rd_addr;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            parity_err <= 1'b0;
        end else begin
            parity_err <= rx_active && !(st_par_ok && rd_par_ok);
        end
    end
endmodule // sxal_link
`default_nettype wire

// ==== verification/sxal_link_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module sxal_link_chk
    import sxal_pkg::*;
#(
    parameter int NUM_PORTS = 16
) (
    input wire logic                   core_clk,
    input wire logic                   nrst,
    input wire sxal_role_t             role,
    input wire logic [NUM_PORTS*9-1:0] store_addr_local,
    input wire logic [NUM_PORTS-1:0]   store_valid_local,
    input wire logic [NUM_PORTS*9-1:0] read_addr_local,
    input wire logic [NUM_PORTS-1:0]   read_valid_local,
    input wire logic                   frame_sync_out,
    input wire logic                   frame_sync_out_oe,
    input wire logic                   frame_sync_in,
    input wire logic [10:0]            store_addr_bus_in,
    input wire logic [10:0]            store_addr_bus_out,
    input wire logic                   store_addr_bus_oe,
    input wire logic [10:0]            read_addr_bus_in,
    input wire logic [10:0]            read_addr_bus_out,
    input wire logic                   read_addr_bus_oe,
    input wire logic                   in_cmd_strobe,
    input wire logic [3:0]             in_cmd_port,
    input wire sxal_action_t           in_cmd_action,
    input wire logic [8:0]             in_cmd_addr,
    input wire logic                   out_cmd_strobe,
    input wire sxal_action_t           out_cmd_action
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // slot tracker follows the design's own sync, so a late pulse shows up as wrong words
    logic [3:0] slot;
    wire  [3:0] cur = frame_sync_out ? 4'h0 : slot;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            slot <= 4'h0;
        else
            slot <= cur + 4'h1;
    end
    function automatic sxal_action_t act(logic [10:0] w);
        if (!(^w) || !w[9])
            return SXAL_ACT_IDLE;
        return w[8:0] == 9'h0 ? SXAL_ACT_DISCARD : SXAL_ACT_STORE;
    endfunction
    a_alone_tristate: assert property (role == SXAL_ROLE_ALONE |=>
        !store_addr_bus_oe && !read_addr_bus_oe && !frame_sync_out_oe) else $error("bus driven while alone");
    a_store_parity: assert property (store_addr_bus_oe |-> ^store_addr_bus_out) else $error("store parity");
    a_read_parity: assert property (read_addr_bus_oe |-> ^read_addr_bus_out) else $error("read parity");
    a_store_slot: assert property (store_addr_bus_oe |-> store_addr_bus_out[9:0] ==
        {1'($past(store_valid_local) >> cur), 9'($past(store_addr_local) >> (cur * 9))}) else $error("store slot");
    a_read_slot: assert property (read_addr_bus_oe |-> read_addr_bus_out[9:0] ==
        {1'($past(read_valid_local) >> cur), 9'($past(read_addr_local) >> (cur * 9))}) else $error("read slot");
    a_sync_frame: assert property (disable iff (!nrst || role != SXAL_ROLE_MASTER) frame_sync_out |=>
        !frame_sync_out [*8] ##1 !frame_sync_out [*7] ##1 frame_sync_out) else $error("sync spacing");
    a_slave_lock: assert property (role == SXAL_ROLE_SLAVE && frame_sync_in |=>
        in_cmd_strobe && out_cmd_strobe && in_cmd_port == 4'h0) else $error("slave port 0");
    a_slot_step: assert property (in_cmd_strobe && role == SXAL_ROLE_SLAVE && !frame_sync_in |=>
        in_cmd_strobe && in_cmd_port == $past(in_cmd_port) + 4'h1) else $error("slave port step");
    a_in_action: assert property (in_cmd_strobe |-> in_cmd_action == act($past(store_addr_bus_in)) &&
        (in_cmd_action != SXAL_ACT_STORE || in_cmd_addr == $past(store_addr_bus_in[8:0]))) else $error("in action");
    a_out_action: assert property (out_cmd_strobe |->
        out_cmd_action == act($past(read_addr_bus_in))) else $error("out action");
endmodule // sxal_link_chk
bind sxal_link sxal_link_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.core_clk, .nrst, .role, .store_addr_local,
    .store_valid_local, .read_addr_local, .read_valid_local, .frame_sync_out, .frame_sync_out_oe, .frame_sync_in,
    .store_addr_bus_in, .store_addr_bus_out, .store_addr_bus_oe, .read_addr_bus_in, .read_addr_bus_out,
    .read_addr_bus_oe, .in_cmd_strobe, .in_cmd_port, .in_cmd_action, .in_cmd_addr, .out_cmd_strobe, .out_cmd_action);
`default_nettype wire

// ==== verification/sxal_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sxal_master_model (
    input  wire logic         core_clk,
    input  wire logic         run,
    input  wire logic         bad,
    input  wire logic [143:0] sa,
    input  wire logic [15:0]  sv,
    input  wire logic [143:0] ra,
    input  wire logic [15:0]  rv,
    output logic              sync,
    output logic [10:0]       sw,
    output logic [10:0]       rw
);
    logic [3:0] slot = 4'h0;
    initial {sync, sw, rw} = '0;
    function automatic logic [10:0] pack(logic [8:0] a, logic v, logic flip);
        return {~^{v, a} ^ flip, v, a};
    endfunction
    always @(posedge core_clk) begin
        if (run) begin
            slot <= slot + 4'h1;
            sync <= slot == 4'h0;
            sw   <= pack(sa[slot*9 +: 9], sv[slot], bad && slot == 4'h3);
            rw   <= pack(ra[slot*9 +: 9], rv[slot], 1'b0);
        end else begin
            slot <= 4'h0;
            sync <= 1'b0;
            // released bus toggles so a stale word never looks fresh
            sw   <= ~sw;
            rw   <= ~rw;
        end
    end
endmodule // sxal_master_model
`default_nettype wire

// ==== verification/test_speed_expansion_address_link.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_speed_expansion_address_link
    import sxal_pkg::*;
;
    logic         core_clk = 1'b0;
    logic         nrst = 1'b0;
    sxal_role_t   role = SXAL_ROLE_ALONE;
    logic [143:0] sa = '0, ra = '0;
    logic [15:0]  sv = '0, rv = '0;
    logic         run = 1'b0, bad = 1'b0, fs, fso, sw_e, rw_e, ist, ost, perr;
    logic [10:0]  sw_i, rw_i, sw_o, rw_o;
    logic [8:0]   iad, oad;
    logic [3:0]   ip, op;
    logic         fse;
    sxal_action_t ia, oa;
    logic [31:0]  rng = 32'h38, qm[$], qs[$];
    int           failures = 0, n_checks = 0, cyc = 0;
    always #2.5 core_clk = ~core_clk;
    sxal_master_model i_far (.core_clk, .run, .bad, .sa, .sv, .ra, .rv, .sync(fs), .sw(sw_i), .rw(rw_i));
    sxal_link #(.NUM_PORTS(16)) i_dut (.core_clk, .nrst, .role, .store_addr_local(sa), .store_valid_local(sv),
        .read_addr_local(ra), .read_valid_local(rv), .frame_sync_out(fso), .frame_sync_out_oe(fse),
        .frame_sync_in(fs), .store_addr_bus_in(sw_i), .store_addr_bus_out(sw_o), .store_addr_bus_oe(sw_e),
        .read_addr_bus_in(rw_i), .read_addr_bus_out(rw_o), .read_addr_bus_oe(rw_e), .in_cmd_strobe(ist),
        .in_cmd_port(ip), .in_cmd_action(ia), .in_cmd_addr(iad), .out_cmd_strobe(ost), .out_cmd_port(op),
        .out_cmd_action(oa), .out_cmd_addr(oad), .parity_err(perr));
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic logic [10:0] wd(logic [143:0] a, logic [15:0] v, int p);
        return {~^{v[p], a[p*9 +: 9]}, v[p], a[p*9 +: 9]};
    endfunction
    function automatic sxal_action_t act(logic [8:0] a, logic v, logic pe);
        if (pe || !v)
            return SXAL_ACT_IDLE;
        return a == 9'h0 ? SXAL_ACT_DISCARD : SXAL_ACT_STORE;
    endfunction
    // addresses only matter with a store action, so they are masked otherwise
    function automatic logic [31:0] pk(logic st, logic [3:0] p, sxal_action_t a, logic [8:0] ad, sxal_action_t b,
                                       logic [8:0] bd, logic pe, logic [3:0] q);
        return {st, pe, a, a == SXAL_ACT_STORE ? ad : 9'h0, b, b == SXAL_ACT_STORE ? bd : 9'h0, q, p};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (failures == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic shuffle();
        for (int p = 0; p < 16; p++) begin
            sa[p*9 +: 9] = 9'(xs());
            ra[p*9 +: 9] = 9'(xs());
        end
        sv = 16'(xs());
        rv = 16'(xs());
        sa[17:9] = 9'h0;
        ra[17:9] = 9'h0;
        sa[44:36] = 9'h1ff;
        {sv[2:1], rv[2:1]} = 4'b0101;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 1000) begin
            failures++;
            print_verdict();
        end
        if (sw_e)
            chk({fse, fso, sw_o, rw_o}, qm.pop_front());
        if (ist)
            chk(pk(ost, ip, ia, iad, oa, oad, perr, op), qs.pop_front());
    end
    initial begin
        repeat (16) @(negedge core_clk);
        nrst = 1'b1;
        for (int pass = 0; pass < 2; pass++) begin
            shuffle();
            role = SXAL_ROLE_MASTER;
            for (int k = 0; k < 32; k++)
                qm.push_back({1'b1, k % 16 == 0, wd(sa, sv, k % 16), wd(ra, rv, k % 16)});
            repeat (32) @(negedge core_clk);
            role = SXAL_ROLE_ALONE;
            repeat (3) @(negedge core_clk);
        end
        for (int pass = 0; pass < 2; pass++) begin
            shuffle();
            bad = pass[0];
            run = 1'b1;
            role = SXAL_ROLE_SLAVE;
            for (int k = 0; k < 32; k++)
                qs.push_back(pk(1'b1, 4'(k), act(sa[k%16*9 +: 9], sv[k%16], bad && k % 16 == 3), sa[k%16*9 +: 9],
                                act(ra[k%16*9 +: 9], rv[k%16], 1'b0), ra[k%16*9 +: 9], bad && k % 16 == 3,
                                4'(k)));
            repeat (32) @(negedge core_clk);
            run = 1'b0;
            @(negedge core_clk);
            role = SXAL_ROLE_ALONE;
            repeat (20) @(negedge core_clk);
        end
        chk(32'(qm.size() + qs.size()), 32'h0);
        print_verdict();
    end
endmodule // test_speed_expansion_address_link
`default_nettype wire
